// ### core/pep_datapath.sv
// Energy datapath: current HPF, product, LPF, positive-only pulse outputs.
// Assumes converter words arrive on the system clock with a valid strobe;
// the rate pins and supply flag come from outside and are synchronised.
//
// Operation
// [R1] Take 16-bit current and voltage samples
// [R2] High-pass filter the current channel only
// [R3] Multiply filtered current by voltage sample
// [R4] Low-pass filter product to real power
// [R5] Accumulate only power above zero
// [R6] Slow pulses from long accumulation
// [R7] Calibration pulse from short accumulation
// [R8] Inactive while supply is low
// [R9] Delay voltage to match current phase
// [R10] Keep 7 kHz band at 450 kHz
// [R11] LPF and accumulation cancel line ripple
// [R12] Negative flag follows sign, updates with cal; code also updates it as soon as the pending sign differs
// [R13] No pulses while negative flag high
// [R14] Slow pulses are active low
// [R15] Rate code picks slow threshold exponent
// [R16] Emit pulse and subtract threshold; code also subtracts when a running pulse or negative sign blocks the pulse
// [R17] Low supply clears accumulators, idles outputs
module pep_datapath
    import pep_pkg::*;
(
    input  wire logic                SYS_CLK_I,
    input  wire logic                SYS_RST_I,
    input  wire logic [SAMPLE_W-1:0] CURRENT_CHANNEL_I,
    input  wire logic [SAMPLE_W-1:0] VOLTAGE_CHANNEL_I,
    input  wire logic                SAMPLE_VALID_I,
    output logic                     SAMPLE_READY_O,
    input  wire logic                RATE_SELECT_LO_I,
    input  wire logic                RATE_SELECT_HI_I,
    input  wire logic                CAL_RATE_SELECT_I,
    input  wire logic                SUPPLY_OK_I,
    output logic                     SLOW_PULSE_A_N_O,
    output logic                     SLOW_PULSE_B_N_O,
    output logic                     CAL_PULSE_OUT_O,
    output logic                     NEGATIVE_POWER_FLAG_O
);
    // Pin synchronisers; stage one feeds only stage two
    logic [3:0] sync1;
    logic [3:0] sync2;
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {SUPPLY_OK_I, CAL_RATE_SELECT_I,
                      RATE_SELECT_HI_I, RATE_SELECT_LO_I};
            sync2 <= sync1;
        end
    end
    logic [1:0] rate_code;
    logic       cal_sel;
    logic       supply_ok;
    assign rate_code = sync2[1:0];
    assign cal_sel   = sync2[2];
    assign supply_ok = sync2[3];

    // Input FIFO; drained once per oscillator tick, so it back-pressures
    pep_sample_t fifo_in;
    pep_sample_t fifo_out;
    logic        fifo_valid;
    logic        tick;
    assign fifo_in = '{cur: CURRENT_CHANNEL_I, volt: VOLTAGE_CHANNEL_I}; // R1
    pep_fifo #(.WIDTH(2*SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (SYS_CLK_I),
        .rst_i       (SYS_RST_I),
        .in_data_i   (fifo_in),
        .in_valid_i  (SAMPLE_VALID_I),
        .in_ready_o  (SAMPLE_READY_O),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_valid),
        .out_ready_i (tick)
    );

    pep_state_t state;
    pep_state_t next_state;
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic       take;

    logic signed [SAMPLE_W+HPF_SHIFT-1:0] hpf_avg;
    logic signed [SAMPLE_W+HPF_SHIFT-1:0] next_hpf_avg;
    logic signed [SAMPLE_W-1:0]           hpf_out;
    logic signed [SAMPLE_W-1:0]           next_hpf_out;
    logic signed [SAMPLE_W-1:0]           volt_d;
    logic signed [SAMPLE_W-1:0]           next_volt_d;
    logic signed [PROD_W-1:0]             prod;
    logic signed [PROD_W-1:0]             next_prod;
    logic signed [PROD_W+LPF_SHIFT-1:0]   lpf;
    logic signed [PROD_W+LPF_SHIFT-1:0]   next_lpf;
    logic signed [PROD_W-1:0]             power;

    logic [ACC_W-1:0] slow_acc;
    logic [ACC_W-1:0] next_slow_acc;
    logic [ACC_W-1:0] cal_acc;
    logic [ACC_W-1:0] next_cal_acc;
    logic [ACC_W-1:0] slow_thr;
    logic [ACC_W-1:0] cal_thr;
    logic [4:0]       pw_cnt;
    logic [4:0]       next_pw_cnt;
    logic [4:0]       cw_cnt;
    logic [4:0]       next_cw_cnt;
    logic             phase_b;
    logic             next_phase_b;
    logic             slow_a;
    logic             next_slow_a;
    logic             slow_b;
    logic             next_slow_b;
    logic             cal_p;
    logic             next_cal_p;
    logic             neg;
    logic             next_neg;
    logic             neg_pend;
    logic             next_neg_pend;

    always_comb begin
        next_state   = supply_ok ? PEP_RUN : PEP_INACTIVE; // R8
        next_div_cnt = (div_cnt == 8'(SAMPLE_DIV - 1)) ? 8'h00
                       : div_cnt + 8'h01;
        tick         = (div_cnt == 8'h00);
        take         = tick && fifo_valid;
    end

    // Filter chain: one step per oscillator tick, 450 kHz rate keeps 7 kHz
    always_comb begin
        logic signed [SAMPLE_W+HPF_SHIFT-1:0] cur_ext;
        logic signed [SAMPLE_W+HPF_SHIFT-1:0] avg_q;
        cur_ext      = {{HPF_SHIFT{fifo_out.cur[SAMPLE_W-1]}}, fifo_out.cur};
        avg_q        = hpf_avg >>> HPF_SHIFT;
        next_hpf_avg = hpf_avg;
        next_hpf_out = hpf_out;
        next_volt_d  = volt_d;
        next_prod    = prod;
        next_lpf     = lpf;
        if (take) begin // R10
            // Running mean removes DC offset from current only
            next_hpf_avg = hpf_avg + cur_ext - avg_q; // R2
            next_hpf_out = SAMPLE_W'(cur_ext - avg_q); // R2
            // Voltage delayed one step to align with HPF output; crude
            // lead compensation, adequate below 1 kHz at this rate
            next_volt_d  = fifo_out.volt
                           - (fifo_out.volt >>> PHASE_SHIFT); // R9
            next_prod    = hpf_out * volt_d; // R3
            // One-pole LPF extracts the DC term, damps 2w ripple
            next_lpf     = lpf + (PROD_W+LPF_SHIFT)'(prod)
                           - (lpf >>> LPF_SHIFT); // R4 R11
        end
    end
    assign power = PROD_W'(lpf >>> LPF_SHIFT);

    // Thresholds: slow exponent shrinks by one per rate code step
    always_comb begin
        slow_thr = ACC_W'(1) << (SLOW_EXP_BASE - int'(rate_code)); // R15
        cal_thr  = cal_sel ? (slow_thr >> (CAL_DIV_EXP - CAL_HALF_EXP))
                           : (slow_thr >> CAL_DIV_EXP); // R7
    end

    always_comb begin
        next_slow_acc = slow_acc;
        next_cal_acc  = cal_acc;
        next_phase_b  = phase_b;
        next_neg      = neg;
        next_neg_pend = neg_pend;
        next_pw_cnt   = (pw_cnt != 5'h00) ? pw_cnt - 5'h01 : 5'h00;
        next_cw_cnt   = (cw_cnt != 5'h00) ? cw_cnt - 5'h01 : 5'h00;
        next_slow_a   = slow_a;
        next_slow_b   = slow_b;
        next_cal_p    = cal_p;
        if (pw_cnt == 5'h01) begin
            next_slow_a = 1'b1;
            next_slow_b = 1'b1;
        end
        if (cw_cnt == 5'h01) begin
            next_cal_p = 1'b0;
        end
        if (take) begin
            next_neg_pend = power[PROD_W-1];
            if (!power[PROD_W-1] && !neg) begin // R5 R13
                next_slow_acc = slow_acc + ACC_W'(power); // R6
                next_cal_acc  = cal_acc + ACC_W'(power); // R7
            end
        end
        if (slow_acc >= slow_thr) begin
            next_slow_acc = next_slow_acc - slow_thr; // R16
            // Pending sign also blocks, flag may rise this cycle
            if (!neg && !neg_pend && pw_cnt == 5'h00) begin // R13
                // Alternate outputs so a stepper sees two phases
                next_slow_a  = phase_b; // R14
                next_slow_b  = !phase_b; // R14
                next_phase_b = !phase_b;
                next_pw_cnt  = 5'(PULSE_CYC);
            end
        end
        if (cal_acc >= cal_thr || neg != neg_pend) begin
            if (cal_acc >= cal_thr) begin
                next_cal_acc = next_cal_acc - cal_thr; // R16
            end
            // Flag moves at a cal event or as soon as the pending sign differs, never latched
            next_neg = neg_pend; // R12
            if (!neg_pend && cal_acc >= cal_thr && cw_cnt == 5'h00) begin
                next_cal_p  = 1'b1; // R13
                next_cw_cnt = 5'(PULSE_CYC);
            end
        end
        if (state == PEP_INACTIVE) begin
            next_slow_acc = '0; // R17
            next_cal_acc  = '0; // R17
            next_slow_a   = 1'b1; // R17
            next_slow_b   = 1'b1; // R17
            next_cal_p    = 1'b0; // R17
            next_neg      = 1'b0;
            next_neg_pend = 1'b0;
            next_pw_cnt   = 5'h00;
            next_cw_cnt   = 5'h00;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state    <= PEP_INACTIVE;
            div_cnt  <= 8'h00;
            hpf_avg  <= '0;
            hpf_out  <= '0;
            volt_d   <= '0;
            prod     <= '0;
            lpf      <= '0;
            slow_acc <= '0;
            cal_acc  <= '0;
            pw_cnt   <= 5'h00;
            cw_cnt   <= 5'h00;
            phase_b  <= 1'b0;
            slow_a   <= 1'b1;
            slow_b   <= 1'b1;
            cal_p    <= 1'b0;
            neg      <= 1'b0;
            neg_pend <= 1'b0;
        end else begin
            state    <= next_state;
            div_cnt  <= next_div_cnt;
            hpf_avg  <= next_hpf_avg;
            hpf_out  <= next_hpf_out;
            volt_d   <= next_volt_d;
            prod     <= next_prod;
            lpf      <= next_lpf;
            slow_acc <= next_slow_acc;
            cal_acc  <= next_cal_acc;
            pw_cnt   <= next_pw_cnt;
            cw_cnt   <= next_cw_cnt;
            phase_b  <= next_phase_b;
            slow_a   <= next_slow_a;
            slow_b   <= next_slow_b;
            cal_p    <= next_cal_p;
            neg      <= next_neg;
            neg_pend <= next_neg_pend;
        end
    end

    assign SLOW_PULSE_A_N_O      = slow_a;
    assign SLOW_PULSE_B_N_O      = slow_b;
    assign CAL_PULSE_OUT_O       = cal_p;
    assign NEGATIVE_POWER_FLAG_O = neg;
endmodule // pep_datapath

// ### core/pep_pkg.sv
// Package for the positive energy pulse datapath: constants and carriers.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package pep_pkg;
    localparam int SAMPLE_W      = 16;
    localparam int PROD_W        = 32;
    localparam int ACC_W         = 40;
    localparam int FIFO_DEPTH    = 4;
    localparam int CLK_HZ        = 25000000;
    localparam int OSC_HZ        = 450000;
    // Sample strobe period in clock cycles (oscillator rate emulated)
    localparam int SAMPLE_DIV    = CLK_HZ / OSC_HZ;
    localparam int HPF_SHIFT     = 10;
    localparam int LPF_SHIFT     = 12;
    localparam int PHASE_SHIFT   = 6;
    // Slow threshold exponent for code 00; each code step lowers it by one
    localparam int SLOW_EXP_BASE = 35;
    localparam int CAL_DIV_EXP   = 11;
    localparam int CAL_HALF_EXP  = 3;
    localparam int PULSE_CYC     = 16;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] cur;
        logic signed [SAMPLE_W-1:0] volt;
    } pep_sample_t;

    typedef enum logic [1:0] {
        PEP_INACTIVE = 2'b00,
        PEP_RUN      = 2'b01
    } pep_state_t;
endpackage : pep_pkg

// ### core/pep_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset is synchronous active high.
module pep_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;
    logic             ready_q;
    logic             next_ready;

    // Registered so the ready pin comes from a flop
    assign in_ready_o  = ready_q;
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_comb begin
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
        next_ready  = (next_count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            ready_q <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            ready_q <= next_ready;
        end
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule // pep_fifo

// ### bench/pep_datapath_sva.sv
// Checker on the datapath top ports.
// Assumes one clock and a synchronous active-high reset.
module pep_datapath_sva
    import pep_pkg::*;
(
    input wire logic                SYS_CLK_I,
    input wire logic                SYS_RST_I,
    input wire logic [SAMPLE_W-1:0] CURRENT_CHANNEL_I,
    input wire logic [SAMPLE_W-1:0] VOLTAGE_CHANNEL_I,
    input wire logic                SAMPLE_VALID_I,
    input wire logic                SAMPLE_READY_O,
    input wire logic                RATE_SELECT_LO_I,
    input wire logic                RATE_SELECT_HI_I,
    input wire logic                CAL_RATE_SELECT_I,
    input wire logic                SUPPLY_OK_I,
    input wire logic                SLOW_PULSE_A_N_O,
    input wire logic                SLOW_PULSE_B_N_O,
    input wire logic                CAL_PULSE_OUT_O,
    input wire logic                NEGATIVE_POWER_FLAG_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    int   cal_len;
    int   a_len;
    int   b_len;
    logic last_a;
    // Run lengths of each pulse; widths are judged at the trailing edge
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            cal_len <= 0;
            a_len   <= 0;
            b_len   <= 0;
            last_a  <= 1'b0;
        end else begin
            cal_len <= CAL_PULSE_OUT_O ? cal_len + 1 : 0;
            a_len   <= !SLOW_PULSE_A_N_O ? a_len + 1 : 0;
            b_len   <= !SLOW_PULSE_B_N_O ? b_len + 1 : 0;
            if (!SLOW_PULSE_A_N_O) last_a <= 1'b1;
            if (!SLOW_PULSE_B_N_O) last_a <= 1'b0;
        end
    end
    // Supply drop may cut a pulse short, so widths need supply two back
    AST_CAL_WIDTH: assert property ($fell(CAL_PULSE_OUT_O)
        && $past(SUPPLY_OK_I, 2) |-> cal_len == PULSE_CYC)
        else $error("cal pulse width wrong");
    AST_A_WIDTH: assert property ($rose(SLOW_PULSE_A_N_O)
        && $past(SUPPLY_OK_I, 2) |-> a_len == PULSE_CYC)
        else $error("slow a width wrong");
    AST_B_WIDTH: assert property ($rose(SLOW_PULSE_B_N_O)
        && $past(SUPPLY_OK_I, 2) |-> b_len == PULSE_CYC)
        else $error("slow b width wrong");
    AST_NO_OVERLAP: assert property (SLOW_PULSE_A_N_O
        || SLOW_PULSE_B_N_O)
        else $error("slow pulses overlap");
    AST_ALT_A: assert property ($fell(SLOW_PULSE_A_N_O) |-> !last_a)
        else $error("slow a out of turn");
    AST_ALT_B: assert property ($fell(SLOW_PULSE_B_N_O) |-> last_a)
        else $error("slow b out of turn");
    AST_NEG_QUIET: assert property ($rose(CAL_PULSE_OUT_O)
        || $fell(SLOW_PULSE_A_N_O) || $fell(SLOW_PULSE_B_N_O)
        |-> !NEGATIVE_POWER_FLAG_O)
        else $error("pulse while negative");
    AST_SUPPLY_IDLE: assert property (!SUPPLY_OK_I [*5] |->
        !CAL_PULSE_OUT_O && SLOW_PULSE_A_N_O && SLOW_PULSE_B_N_O)
        else $error("outputs active at low supply");
    AST_RESET_IDLE: assert property ($fell(SYS_RST_I) |->
        !CAL_PULSE_OUT_O && SLOW_PULSE_A_N_O && SLOW_PULSE_B_N_O
        && !NEGATIVE_POWER_FLAG_O && SAMPLE_READY_O)
        else $error("outputs not idle after reset");
    AST_READY_FALL: assert property ($fell(SAMPLE_READY_O)
        |-> $past(SAMPLE_VALID_I))
        else $error("ready fell without a word");
    COV_CAL: cover property ($rose(CAL_PULSE_OUT_O));
    COV_NEG: cover property ($rose(NEGATIVE_POWER_FLAG_O));
    COV_FULL: cover property (SAMPLE_VALID_I && !SAMPLE_READY_O);
endmodule // pep_datapath_sva

bind pep_datapath pep_datapath_sva u_sva (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
    .CURRENT_CHANNEL_I(CURRENT_CHANNEL_I),
    .VOLTAGE_CHANNEL_I(VOLTAGE_CHANNEL_I),
    .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_READY_O(SAMPLE_READY_O),
    .RATE_SELECT_LO_I(RATE_SELECT_LO_I),
    .RATE_SELECT_HI_I(RATE_SELECT_HI_I),
    .CAL_RATE_SELECT_I(CAL_RATE_SELECT_I), .SUPPLY_OK_I(SUPPLY_OK_I),
    .SLOW_PULSE_A_N_O(SLOW_PULSE_A_N_O),
    .SLOW_PULSE_B_N_O(SLOW_PULSE_B_N_O),
    .CAL_PULSE_OUT_O(CAL_PULSE_OUT_O),
    .NEGATIVE_POWER_FLAG_O(NEGATIVE_POWER_FLAG_O));

// ### bench/pep_pulse_counter.sv
// Counter on the pulse outputs, as a meter register or MCU would be.
// Assumes pulses are sampled on the system clock.
module pep_pulse_counter (
    input  wire logic clk_i,
    input  wire logic clr_i,
    input  wire logic slow_a_n_i,
    input  wire logic slow_b_n_i,
    input  wire logic cal_i,
    output int        cal_cnt_o,
    output int        slow_cnt_o,
    output logic      order_err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic a_q;
    logic b_q;
    logic c_q;
    logic last_a;
    always @(posedge clk_i) begin
        if (clr_i) begin
            {cal_cnt_o, slow_cnt_o} <= '0;
            {a_q, b_q, c_q, last_a, order_err_o} <= 5'b11000;
        end else begin
            {a_q, b_q, c_q} <= {slow_a_n_i, slow_b_n_i, cal_i};
            if (!c_q && cal_i) cal_cnt_o <= cal_cnt_o + 1;
            // Falling edges count, A and B taking turns
            if (a_q && !slow_a_n_i) begin
                slow_cnt_o <= slow_cnt_o + 1;
                if (last_a) order_err_o <= 1'b1;
                last_a <= 1'b1;
            end
            if (b_q && !slow_b_n_i) begin
                slow_cnt_o <= slow_cnt_o + 1;
                if (!last_a) order_err_o <= 1'b1;
                last_a <= 1'b0;
            end
        end
    end
endmodule // pep_pulse_counter

// ### bench/pep_datapath_tb_top.sv
// Testbench for the datapath: streams word pairs, counts pulses.
// Assumes the checker is bound in and the counter stands at the outputs.
module pep_datapath_tb_top import pep_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk = 0;
    logic                rst = 1;
    logic                valid = 0;
    logic                lo = 0;
    logic                hi = 0;
    logic                csel = 0;
    logic                sup = 0;
    logic                clr = 1;
    logic                saw_full = 0;
    logic [SAMPLE_W-1:0] cur = '0;
    logic [SAMPLE_W-1:0] volt = '0;
    wire logic           ready, a_n, b_n, cal, flag, oerr;
    int                  cal_cnt, slow_cnt, cycles = 0;
    int                  mismatches = 0;
    int                  n_checks = 0;

    pep_datapath DUT (.SYS_CLK_I(clk), .SYS_RST_I(rst),
        .CURRENT_CHANNEL_I(cur), .VOLTAGE_CHANNEL_I(volt),
        .SAMPLE_VALID_I(valid), .SAMPLE_READY_O(ready),
        .RATE_SELECT_LO_I(lo), .RATE_SELECT_HI_I(hi),
        .CAL_RATE_SELECT_I(csel), .SUPPLY_OK_I(sup),
        .SLOW_PULSE_A_N_O(a_n), .SLOW_PULSE_B_N_O(b_n),
        .CAL_PULSE_OUT_O(cal), .NEGATIVE_POWER_FLAG_O(flag));
    pep_pulse_counter u_cnt (.clk_i(clk), .clr_i(clr),
        .slow_a_n_i(a_n), .slow_b_n_i(b_n), .cal_i(cal),
        .cal_cnt_o(cal_cnt), .slow_cnt_o(slow_cnt), .order_err_o(oerr));

    always #20 clk = ~clk;
    // Ceiling well above the ~70k cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (valid && ready === 1'b0) saw_full <= 1'b1;
        if (cycles == 90000) begin
            mismatches++;
            results();
        end
    end

    task check(input string name, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task results;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task restart(input logic s, h, l, c);
        @(negedge clk);
        {rst, clr, sup, hi, lo, csel} = {2'b11, s, h, l, c};
        repeat (20) @(negedge clk);
        {rst, clr} = 2'b00;
    endtask

    // Square wave, voltage in phase or inverted by neg; in phase keeps the product positive past the HPF
    task stream(input int n, input bit neg);
        int a;
        for (int i = 0; i < n; i++) begin
            a = i[3] ? -32000 : 32000;
            cur = 16'(a);
            volt = 16'(neg ? -a : a);
            valid = 1'b1;
            while (ready !== 1'b1) @(negedge clk);
            @(negedge clk);
        end
        valid = 1'b0;
        repeat (300) @(negedge clk);
    endtask

    initial begin
        int prev;
        int c3;
        restart(0, 0, 0, 0);
        check("idle", {a_n, b_n, cal, flag, ready}, 5'b11001);
        stream(100, 0);
        check("low_supply_cal", cal_cnt, 0);
        restart(1, 1, 1, 0);
        stream(150, 1);
        check("neg_flag", flag, 1'b1);
        check("neg_cal", cal_cnt + slow_cnt, 0);
        check("fifo_full", saw_full, 1'b1);
        prev = 0;
        for (int k = 0; k < 4; k++) begin
            restart(1, k[1], k[0], 0);
            stream(200, 0);
            check("pos_flag", flag, 1'b0);
            check("rate_order", cal_cnt >= prev, 1'b1);
            check("slow_vs_cal", slow_cnt * 256 <= cal_cnt + 256, 1);
            prev = cal_cnt;
        end
        c3 = prev;
        check("cal_seen", c3 > 0, 1'b1);
        restart(1, 1, 1, 1);
        stream(200, 0);
        check("cal_select", cal_cnt < c3, 1'b1);
        check("slow_order", oerr, 1'b0);
        results();
    end
endmodule // pep_datapath_tb_top
